// ### common/pusc_pkg.sv
// Function
// - The power-on hold stays asserted until both core supply rails are good.
// - Core logic is inactive while the power-on hold is asserted and active only after its release.
// - In a blank device every user pin is high impedance with a weak pull-up.
// - Pins keep the blank state until core, auxiliary and bank supplies are all valid and the device is configured, then take user settings.
// - An active-low sleep control pin selects sleep when low and normal operation when high.
// - In sleep all user logic stops, registers and memory are not retained, and pins float.
// - The test access port and programming circuitry work in normal mode only, not in sleep or off.
// - The sleep input carries a glitch filter so short low pulses cause no sleep entry.
// - Sleep is entered a few hundred nanoseconds after a held low, and left after the release time.
// - The top-bank PCI clamps are enabled only with all supplies valid and the device configured.
package pusc_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // Low time needed before sleep is taken, a least time so rounded up
    localparam int SLEEP_ENTRY_NS = 500;
    localparam int SLEEP_ENTRY_CYCLES = (SLEEP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // High time needed before wake is taken
    localparam int WAKE_FILT_NS = 100;
    localparam int WAKE_FILT_CYCLES = (WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Reset hold on user logic after wake
    localparam int RESTORE_NS = 200;
    localparam int RESTORE_CYCLES = (RESTORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;

    typedef enum logic [2:0] {
        PUSC_POR = 3'h0,
        PUSC_BLANK = 3'h1,
        PUSC_RUN = 3'h3,
        PUSC_SLEEP = 3'h2,
        PUSC_RESTORE = 3'h6
    } pusc_state_t;
endpackage : pusc_pkg

// ### common/pusc_sleep_if.sv
`timescale 1ns/1ns
// Filtered sleep request from the pin filter to the sequencer
interface pusc_sleep_if;
    logic sleep_req;
    modport filt (output sleep_req);
    modport ctrl (input sleep_req);
endinterface : pusc_sleep_if

// ### src/pusc_sleep_filter.sv
`timescale 1ns/1ns
module pusc_sleep_filter
    import pusc_pkg::*;
#(
    parameter int ENTRY_CYCLES = SLEEP_ENTRY_CYCLES,
    parameter int WAKE_CYCLES = WAKE_FILT_CYCLES
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic sleep_ctrl_low,
    pusc_sleep_if.filt sif
);
    localparam logic [CNT_W-1:0] ENTRY_LAST = CNT_W'(ENTRY_CYCLES - 1);
    localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYCLES - 1);

    // Counter width bounds both windows, refused at elaboration
    if (ENTRY_CYCLES < 1 || ENTRY_CYCLES > 2 ** CNT_W || WAKE_CYCLES < 1 || WAKE_CYCLES > 2 ** CNT_W)
    begin : g_bad_counts
        $error("pusc_sleep_filter: filter counts out of range");
    end

    typedef struct packed {
        logic req;
        logic [CNT_W-1:0] cnt;
    } pusc_filt_t;

    pusc_filt_t r;
    pusc_filt_t next_r;

    // Level must differ from the current request for a full window before it flips
    // glitch filter window
    always_comb
    begin
        next_r = r;
        if ((!sleep_ctrl_low) == r.req)
        begin
            next_r.cnt = '0; // Any bounce restarts the window
        end
        else if (r.cnt == (r.req ? WAKE_LAST : ENTRY_LAST))
        begin
            next_r.req = !r.req;
            next_r.cnt = '0;
        end
        else
        begin
            next_r.cnt = r.cnt + 1'b1;
        end
    end

    // Reset to normal, as the pin pull-up would read
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign sif.sleep_req = r.req;

    // Helper: run of consecutive low samples
    logic [15:0] low_run;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_run <= '0;
        end
        else
        begin
            low_run <= sleep_ctrl_low ? 16'h0000 : (low_run == 16'hFFFF ? low_run : low_run + 16'h0001);
        end
    end

    property p_glitch_reject;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(sif.sleep_req) |-> low_run >= 16'(ENTRY_CYCLES);
    endproperty
    a_glitch_reject: assert property (p_glitch_reject) else $error("sleep request without full low window");

    property p_entry_bound;
        @(posedge ref_clk) disable iff (!rst_n)
        (!sif.sleep_req && !sleep_ctrl_low && r.cnt == ENTRY_LAST) |=> sif.sleep_req;
    endproperty
    a_entry_bound: assert property (p_entry_bound) else $error("sleep request late after low window");
endmodule : pusc_sleep_filter

// ### src/pusc_top.sv
`timescale 1ns/1ns
module pusc_top
    import pusc_pkg::*;
#(
    parameter int ENTRY_CYCLES = SLEEP_ENTRY_CYCLES,
    parameter int WAKE_CYCLES = WAKE_FILT_CYCLES,
    parameter int HOLD_CYCLES = RESTORE_CYCLES
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic vcc_good,
    input wire logic vccaux_good,
    input wire logic vccio_good,
    input wire logic configured,
    input wire logic configuring,
    input wire logic sleep_ctrl_low,
    output logic por_hold,
    output logic core_active,
    output logic core_reset_n,
    output logic mem_clear,
    output logic pin_hiz,
    output logic pin_pullup_en,
    output logic pin_user_cfg,
    output logic tap_prog_en,
    output logic pci_clamp_en,
    output logic sleeping
);
    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);

    // Hold counter width bounds the restore time, refused at elaboration
    if (HOLD_CYCLES < 1 || HOLD_CYCLES > 2 ** CNT_W)
    begin : g_bad_hold
        $error("pusc_top: restore hold out of range");
    end

    typedef struct packed {
        pusc_state_t state;
        logic [CNT_W-1:0] cnt;
        logic por_hold;
        logic core_active;
        logic mem_clear;
        logic pin_hiz;
        logic pin_pullup_en;
        logic pin_user_cfg;
        logic tap_prog_en;
        logic pci_clamp_en;
        logic sleeping;
    } pusc_ctl_t;

    pusc_ctl_t r;
    pusc_ctl_t next_r;
    logic core_ok;
    logic all_ok;
    logic sleep_go;

    pusc_sleep_if sif ();

    pusc_sleep_filter #(
        .ENTRY_CYCLES(ENTRY_CYCLES),
        .WAKE_CYCLES(WAKE_CYCLES)
    ) u_filter (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sleep_ctrl_low(sleep_ctrl_low),
        .sif(sif)
    );

    // Supply qualifiers
    assign core_ok = vcc_good && vccaux_good;
    assign all_ok = core_ok && vccio_good;
    assign sleep_go = sif.sleep_req && !configuring;

    // Sequencer: a core rail loss always falls back to the power-on hold
    always_comb
    begin
        next_r = r;
        unique case (r.state)
            PUSC_POR:
            begin
                if (core_ok)
                begin
                    next_r.state = PUSC_BLANK;
                end
            end
            PUSC_BLANK:
            begin
                if (!core_ok)
                begin
                    next_r.state = PUSC_POR;
                end
                else if (sleep_go)
                begin
                    next_r.state = PUSC_SLEEP;
                end
                else if (all_ok && configured)
                begin
                    next_r.state = PUSC_RUN;
                end
            end
            PUSC_RUN:
            begin
                if (!core_ok)
                begin
                    next_r.state = PUSC_POR;
                end
                else if (sleep_go)
                begin
                    next_r.state = PUSC_SLEEP;
                end
                else if (!all_ok || !configured)
                begin
                    next_r.state = PUSC_BLANK; // Bank rail or configuration lost, back to blank pins
                end
            end
            PUSC_SLEEP:
            begin
                next_r.cnt = '0;
                if (!core_ok)
                begin
                    next_r.state = PUSC_POR;
                end
                else if (!sif.sleep_req)
                begin
                    next_r.state = PUSC_RESTORE;
                end
            end
            PUSC_RESTORE:
            begin
                if (!core_ok)
                begin
                    next_r.state = PUSC_POR;
                end
                else if (sleep_go)
                begin
                    next_r.state = PUSC_SLEEP;
                end
                else if (r.cnt == HOLD_LAST)
                begin
                    next_r.state = (all_ok && configured) ? PUSC_RUN : PUSC_BLANK;
                end
                else
                begin
                    next_r.cnt = r.cnt + 1'b1;
                end
            end
            default:
            begin
                next_r.state = PUSC_POR; // Unused codes recover to the hold
            end
        endcase

        // Outputs decoded from the next state so every port is a flop
        // core only after hold release
        next_r.por_hold = (next_r.state == PUSC_POR);
        next_r.core_active = (next_r.state == PUSC_BLANK) || (next_r.state == PUSC_RUN);
        next_r.mem_clear = (next_r.state == PUSC_SLEEP) || (next_r.state == PUSC_RESTORE);
        next_r.pin_hiz = (next_r.state != PUSC_RUN);
        next_r.pin_pullup_en = (next_r.state != PUSC_RUN) && (next_r.state != PUSC_SLEEP);
        next_r.pin_user_cfg = (next_r.state == PUSC_RUN);
        // port dead in sleep and off
        next_r.tap_prog_en = (next_r.state != PUSC_POR) && (next_r.state != PUSC_SLEEP);
        next_r.pci_clamp_en = (next_r.state == PUSC_RUN);
        next_r.sleeping = (next_r.state == PUSC_SLEEP);
    end

    // Reset puts everything in the power-on hold with blank pins
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '{state: PUSC_POR, cnt: '0, por_hold: 1'b1, core_active: 1'b0, mem_clear: 1'b0,
                   pin_hiz: 1'b1, pin_pullup_en: 1'b1, pin_user_cfg: 1'b0, tap_prog_en: 1'b0,
                   pci_clamp_en: 1'b0, sleeping: 1'b0};
        end
        else
        begin
            r <= next_r;
        end
    end

    // Port drive straight from the state flops
    assign por_hold = r.por_hold;
    assign core_active = r.core_active;
    assign core_reset_n = r.core_active;
    assign mem_clear = r.mem_clear;
    assign pin_hiz = r.pin_hiz;
    assign pin_pullup_en = r.pin_pullup_en;
    assign pin_user_cfg = r.pin_user_cfg;
    assign tap_prog_en = r.tap_prog_en;
    assign pci_clamp_en = r.pci_clamp_en;
    assign sleeping = r.sleeping;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    property p_por_hold;
        !core_ok |=> por_hold && !core_active;
    endproperty
    a_por_hold: assert property (p_por_hold) else $error("hold not asserted on core rail loss");

    property p_core_gate;
        $fell(por_hold) |-> core_active && $past(core_ok);
    endproperty
    a_core_gate: assert property (p_core_gate) else $error("core not started at hold release");

    property p_blank_pins;
        (por_hold || (core_active && !pin_user_cfg)) |-> pin_hiz && pin_pullup_en;
    endproperty
    a_blank_pins: assert property (p_blank_pins) else $error("blank pins not floating with pull-up");

    property p_user_cfg;
        $rose(pin_user_cfg) |-> $past(all_ok && configured) && !pin_hiz;
    endproperty
    a_user_cfg: assert property (p_user_cfg) else $error("user pins taken before rails valid");

    property p_sleep_entry;
        (sleep_go && core_ok && !por_hold) |=> sleeping;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered on request");

    property p_sleep_state;
        sleeping |-> pin_hiz && !pin_pullup_en && !core_active && !core_reset_n && mem_clear;
    endproperty
    a_sleep_state: assert property (p_sleep_state) else $error("sleep outputs wrong");

    property p_tap_off;
        (sleeping || por_hold) |-> !tap_prog_en;
    endproperty
    a_tap_off: assert property (p_tap_off) else $error("test port live in sleep or off");

    property p_no_cfg_sleep;
        (configuring && !sleeping) |=> !sleeping;
    endproperty
    a_no_cfg_sleep: assert property (p_no_cfg_sleep) else $error("sleep entered while configuring");

    property p_pci_clamp;
        pci_clamp_en |-> $past(all_ok) && $past(configured);
    endproperty
    a_pci_clamp: assert property (p_pci_clamp) else $error("clamps on before config");

    property p_restore_hold;
        ($fell(sleeping) && core_ok && $past(core_ok) && !sif.sleep_req) |-> !core_active [*2] ##0 mem_clear;
    endproperty
    a_restore_hold: assert property (p_restore_hold) else $error("user logic not held after wake");
endmodule : pusc_top

// ### tb/pusc_sleep_partner.sv
`timescale 1ns/1ns
// System side of the sleep pin
module pusc_sleep_partner
(
    input wire logic ref_clk,
    input wire logic configuring,
    input wire logic want_sleep,
    output logic sleep_ctrl_low
);
    initial sleep_ctrl_low = 1'h1;
    // Request held back during configuration, the device also ignores it while configuring
    // never low configuring
    always @(posedge ref_clk)
        sleep_ctrl_low <= !(want_sleep && !configuring);
endmodule : pusc_sleep_partner

// ### tb/tb_pusc_top.sv
`timescale 1ns/1ns
module tb_pusc_top;
    // Short windows keep the run brief
    localparam int T_ENTRY = 8;
    localparam int T_WAKE = 3;
    localparam int T_HOLD = 4;
    localparam logic [4:0] RUN = 5'h1E;
    logic ref_clk, rst_n, vcc_good, vccaux_good, vccio_good, configured, configuring, want_sleep;
    logic sleep_ctrl_low, por_hold, core_active, core_reset_n, mem_clear, pin_hiz;
    logic pin_pullup_en, pin_user_cfg, tap_prog_en, pci_clamp_en, sleeping;
    logic [9:0] exp_tab [5] = '{10'h230, 10'h1B4, 10'h18E, 10'h061, 10'h074};
    logic [9:0] e;
    logic [15:0] seed = 16'h1451;
    int bad_count = 0, checked = 0, st, lo, hi, cnt, i, k;
    bit req, run_checks = 0;

    pusc_sleep_partner u_pusc_sleep_partner (.ref_clk(ref_clk), .configuring(configuring),
        .want_sleep(want_sleep), .sleep_ctrl_low(sleep_ctrl_low));
    pusc_top #(.ENTRY_CYCLES(T_ENTRY), .WAKE_CYCLES(T_WAKE), .HOLD_CYCLES(T_HOLD)) u_pusc_top (
        .ref_clk(ref_clk), .rst_n(rst_n), .vcc_good(vcc_good), .vccaux_good(vccaux_good),
        .vccio_good(vccio_good), .configured(configured), .configuring(configuring),
        .sleep_ctrl_low(sleep_ctrl_low), .por_hold(por_hold), .core_active(core_active),
        .core_reset_n(core_reset_n), .mem_clear(mem_clear), .pin_hiz(pin_hiz),
        .pin_pullup_en(pin_pullup_en), .pin_user_cfg(pin_user_cfg), .tap_prog_en(tap_prog_en),
        .pci_clamp_en(pci_clamp_en), .sleeping(sleeping));

    // Clock
    always #5 ref_clk = !ref_clk;

    function automatic int rnd(input int range);
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return int'(seed) % range;
    endfunction : rnd

    task automatic check(input string what, input logic seen, input logic exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("FAIL %s expected %b seen %b", what, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        if (bad_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    // Levels applied at one edge, then held n more edges
    task automatic drive(input logic [4:0] v, input logic s, input int n);
        @(posedge ref_clk);
        {vcc_good, vccaux_good, vccio_good, configured, configuring} <= v;
        want_sleep <= s;
        repeat (n) @(posedge ref_clk);
    endtask : drive

    // Reference model: states 0 hold, 1 blank, 2 run, 3 sleep, 4 restore
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st = 0; lo = 0; hi = 0; cnt = 0; req = 0;
        end
        else
        begin
            if (!(vcc_good && vccaux_good))
                st = 0;
            else if (req && !configuring && st inside {1, 2, 4})
                st = 3;
            else
                case (st)
                    0: st = 1;
                    1: if (vccio_good && configured) st = 2;
                    2: if (!(vccio_good && configured)) st = 1;
                    3: if (!req) begin st = 4; cnt = 0; end
                    default: if (cnt == T_HOLD - 1) st = (vccio_good && configured) ? 2 : 1; else cnt++;
                endcase
            // Filter counts restart on any opposite sample
            if (!req)
            begin
                lo = sleep_ctrl_low ? 0 : lo + 1;
                if (lo == T_ENTRY) begin req = 1; lo = 0; end
            end
            else
            begin
                hi = sleep_ctrl_low ? hi + 1 : 0;
                if (hi == T_WAKE) begin req = 0; hi = 0; end
            end
        end
    end

    // Outputs compared away from the edge, once settled
    always @(negedge ref_clk)
    begin
        if (run_checks)
        begin
            e = exp_tab[st];
            check("por_hold", por_hold, e[9]); // hold flag
            check("core_active", core_active, e[8]); // core enable
            check("core_reset_n", core_reset_n, e[7]); // user reset
            check("mem_clear", mem_clear, e[6]); // memory lost
            check("pin_hiz", pin_hiz, e[5]); // pins floating
            check("pin_pullup_en", pin_pullup_en, e[4]); // blank pull-ups
            check("pin_user_cfg", pin_user_cfg, e[3]); // user settings
            check("tap_prog_en", tap_prog_en, e[2]); // test port
            check("pci_clamp_en", pci_clamp_en, e[1]); // clamp enable
            check("sleeping", sleeping, e[0]); // sleep state
        end
    end

    initial
    begin
        ref_clk = 0; rst_n = 0; want_sleep = 0;
        {vcc_good, vccaux_good, vccio_good, configured, configuring} = 5'h00;
        repeat (12) @(posedge ref_clk);
        // Checks start once reset has surely reached every flop
        run_checks = 1;
        rst_n <= 1;
        // Power-up order, one rail at a time
        drive(5'h00, 0, 3);
        drive(5'h10, 0, 3);
        drive(5'h18, 0, 3);
        drive(5'h1C, 0, 3);
        drive(RUN, 0, 3);
        drive(5'h1A, 0, 3);
        drive(RUN, 0, 3);
        // Short lows, longest one just under the window
        drive(RUN, 1, T_ENTRY - 2);
        drive(RUN, 0, 2);
        for (i = 0; i < 8; i++)
        begin
            drive(RUN, 1, rnd(T_ENTRY - 1));
            drive(RUN, 0, rnd(4));
        end
        // Held low: sleep within T_ENTRY + 4 cycles, bounded wait
        drive(RUN, 1, 0);
        k = 0;
        while (sleeping !== 1'h1 && k < T_ENTRY + 4)
        begin
            @(negedge ref_clk);
            k++;
        end
        if (k == T_ENTRY + 4)
        begin
            bad_count++;
            stop_test();
        end
        // Short highs while asleep, then a real wake
        for (i = 0; i < 6; i++)
        begin
            drive(RUN, 0, rnd(T_WAKE - 1));
            drive(RUN, 1, 2);
        end
        drive(RUN, 0, T_WAKE + T_HOLD + 4);
        // Request while configuring never reaches the pin
        drive(5'h1F, 1, T_ENTRY + 4);
        drive(RUN, 0, 2);
        // Sleep from blank, wake into blank
        drive(5'h1A, 1, T_ENTRY + 4);
        drive(5'h1A, 0, T_WAKE + T_HOLD + 4);
        drive(RUN, 0, 3);
        // Core rail drop while running
        drive(5'h0E, 0, 3);
        drive(RUN, 0, 4);
        // Aux rail drop while asleep, request still standing on return
        drive(RUN, 1, T_ENTRY + 4);
        drive(5'h16, 1, 3);
        // Reset in mid sleep, pin still low afterwards
        drive(RUN, 1, T_ENTRY + 4);
        rst_n <= 0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1;
        drive(RUN, 1, T_ENTRY + 6);
        drive(RUN, 0, T_WAKE + T_HOLD + 6);
        stop_test();
    end
endmodule : tb_pusc_top
